// >>> src/ecct_timer.sv
// Notes on behaviour
// - Mode 10 counts up and clears to zero on each valid edge of A.
// - In clear-and-start mode a capture into B on an A edge also clears the counter.
// - Triggers are sampled and need two equal samples to count as edges.
// - Reverse phase: in mode 10 the selected edge of A clears; the opposite edge captures into A.
// - Reverse-phase capture into register A raises no interrupt A.
// - In reverse phase, a selected edge on B raises interrupt A only.
// - Clear-toggle bit inverts the output on valid A edges in modes 01 and 10; matches use the toggle field.
// - Toggle field: 00 none, 01 match A, 10 match B, 11 either.
// - Both capturing in mode 10: A edge captures B, clears, toggles if clear-toggle is set.
// - Register A capturing from B captures on B edges and raises A.
// - Pulse width: A captures on the opposite edge of A, B on the selected edge.
// - A compare match raises its interrupt and leaves the counter alone.
// - Register A takes its capture trigger from input A or input B.
// - Register B captures only from valid edges of input A.
// - Mode 01 counts up continuously on the count clock.
// - Free-running: after FFFFH the wrap flag sets and the count wraps.
// - Each register is compare or capture independently.
// - Both comparing: matches raise interrupts and toggle the output as the toggle field selects.
// - A comparing, B capturing: A edges capture into B, raise B.
//
// Our own choices: strobed register access and the register addresses.
module ecct_timer (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic [ecct_pkg::ADDR_W-1:0] ADDR,
    input wire logic [ecct_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [ecct_pkg::DATA_W-1:0] RDATA,
    input wire logic TRIGGER_IN_A,
    input wire logic TRIGGER_IN_B,
    output logic TOGGLE_OUT,
    output logic IRQ_A,
    output logic IRQ_B
);
    import ecct_pkg::*;

    // All checks run on the block clock and sleep while reset is held.
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    logic [1:0] mode_sel;
    logic clear_toggle_sel;
    logic wrap_flag;
    logic a_capture;
    logic reverse_phase_sel;
    logic b_capture;
    logic [1:0] output_control;
    logic [1:0] prescale_select;
    logic [1:0] edge_a_sel;
    logic [1:0] edge_b_sel;
    logic [15:0] up_counter;
    logic [15:0] capcmp_reg_a;
    logic [15:0] capcmp_reg_b;
    logic [5:0] div_count;
    logic [5:0] div_limit;
    logic tick;
    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;
    logic running;
    logic edge_a_valid;
    logic edge_a_rev;
    logic edge_b_valid;
    logic cap_a_ev;
    logic cap_b_ev;
    logic clear_ev;
    logic match_a;
    logic match_b;
    logic b_irq_only;
    logic wrap_ev;
    logic toggle_ev;
    logic [1:0] next_mode_sel;
    logic next_clear_toggle_sel;
    logic next_wrap_flag;
    logic next_a_capture;
    logic next_reverse_phase_sel;
    logic next_b_capture;
    logic [1:0] next_output_control;
    logic [1:0] next_prescale_select;
    logic [1:0] next_edge_a_sel;
    logic [1:0] next_edge_b_sel;
    logic [15:0] next_up_counter;
    logic [15:0] next_capcmp_reg_a;
    logic [15:0] next_capcmp_reg_b;
    logic [5:0] next_div_count;
    logic [15:0] next_rdata;
    logic next_toggle_out;
    logic next_irq_a;
    logic next_irq_b;

    // One qualifier per trigger pin, both sampled on the count tick.
    ecct_edge_qual u_qual_a (
        .clock(CLOCK),
        .srst(SRST),
        .pin(TRIGGER_IN_A),
        .sample(tick),
        .rise(rise_a),
        .fall(fall_a)
    );

    ecct_edge_qual u_qual_b (
        .clock(CLOCK),
        .srst(SRST),
        .pin(TRIGGER_IN_B),
        .sample(tick),
        .rise(rise_b),
        .fall(fall_b)
    );

    // Edge selection; the reverse phase is the opposite edge of the same pin.
    always_comb begin
        unique case (prescale_select)
            2'h0: div_limit = DIV_LIMIT_0;
            2'h1: div_limit = DIV_LIMIT_1;
            2'h2: div_limit = DIV_LIMIT_2;
            2'h3: div_limit = DIV_LIMIT_3;
        endcase
        tick = (div_count >= div_limit); // Ends a count above a new limit.
        running = (mode_sel == MODE_FREE) || (mode_sel == MODE_CLEAR);
        edge_a_valid = ((edge_a_sel == EDGE_RISE) && rise_a)
            || ((edge_a_sel == EDGE_FALL) && fall_a)
            || ((edge_a_sel == EDGE_BOTH) && (rise_a || fall_a));
        edge_a_rev = ((edge_a_sel == EDGE_RISE) && fall_a)
            || ((edge_a_sel == EDGE_FALL) && rise_a)
            || ((edge_a_sel == EDGE_BOTH) && (rise_a || fall_a));
        edge_b_valid = ((edge_b_sel == EDGE_RISE) && rise_b)
            || ((edge_b_sel == EDGE_FALL) && fall_b)
            || ((edge_b_sel == EDGE_BOTH) && (rise_b || fall_b));
    end

    // Event decode for captures, clears, matches and wrap.
    always_comb begin
        cap_a_ev = running && a_capture
            && (reverse_phase_sel ? edge_a_rev : edge_b_valid);
        cap_b_ev = running && b_capture && edge_a_valid;
        clear_ev = (mode_sel == MODE_CLEAR) && edge_a_valid;
        match_a = running && tick && !a_capture
            && (up_counter == capcmp_reg_a);
        match_b = running && tick && !b_capture
            && (up_counter == capcmp_reg_b);
        // edge B raises A without capture
        b_irq_only = running && a_capture && reverse_phase_sel
            && edge_b_valid;
        wrap_ev = running && tick && (up_counter == COUNT_MAX);
        // toggle on valid A edges while running if clear-toggle is set, and on matches the toggle field selects
        toggle_ev = (clear_toggle_sel && running && edge_a_valid)
            || (output_control[0] && match_a)
            || (output_control[1] && match_b);
    end

    // Counter, capture registers and interrupt pulses.
    always_comb begin
        next_up_counter = up_counter;
        next_capcmp_reg_a = capcmp_reg_a;
        next_capcmp_reg_b = capcmp_reg_b;
        next_div_count = tick ? 6'h00 : div_count + 6'h01;
        if (WR && ADDR == ADDR_REG_A) begin
            next_capcmp_reg_a = WDATA;
        end
        if (WR && ADDR == ADDR_REG_B) begin
            next_capcmp_reg_b = WDATA;
        end
        // count on each tick, wrapping past the top
        if (running && tick) begin
            next_up_counter = up_counter + COUNT_ONE;
        end
        if (!running || clear_ev) begin
            next_up_counter = RESET_WORD;
        end
        // captures take the count held before the clear
        if (cap_a_ev) begin
            next_capcmp_reg_a = up_counter;
        end
        if (cap_b_ev) begin
            next_capcmp_reg_b = up_counter;
        end
        // no interrupt for a reverse-phase capture
        next_irq_a = match_a || b_irq_only
            || (cap_a_ev && !reverse_phase_sel);
        next_irq_b = match_b || cap_b_ev;
        next_toggle_out = TOGGLE_OUT ^ toggle_ev;
    end

    // Control registers and the wrap flag; a wrap beats a software clear.
    always_comb begin
        next_mode_sel = mode_sel;
        next_clear_toggle_sel = clear_toggle_sel;
        next_wrap_flag = wrap_flag;
        next_a_capture = a_capture;
        next_reverse_phase_sel = reverse_phase_sel;
        next_b_capture = b_capture;
        next_output_control = output_control;
        next_prescale_select = prescale_select;
        next_edge_a_sel = edge_a_sel;
        next_edge_b_sel = edge_b_sel;
        if (WR && ADDR == ADDR_MODE) begin
            next_mode_sel = WDATA[MODE_LO_BIT +: 2];
            next_clear_toggle_sel = WDATA[MODE_CLRTOG_BIT];
            next_wrap_flag = wrap_flag & WDATA[MODE_WRAP_BIT];
        end
        if (WR && ADDR == ADDR_CAPCMP) begin
            next_a_capture = WDATA[CC_A_CAP_BIT];
            next_reverse_phase_sel = WDATA[CC_REV_BIT];
            next_b_capture = WDATA[CC_B_CAP_BIT];
        end
        if (WR && ADDR == ADDR_OUTCTL) begin
            next_output_control = WDATA[1:0];
        end
        if (WR && ADDR == ADDR_PRESCALE) begin
            next_prescale_select = WDATA[PS_DIV_LO +: 2];
            next_edge_a_sel = WDATA[PS_EDGE_A_LO +: 2];
            next_edge_b_sel = WDATA[PS_EDGE_B_LO +: 2];
        end
        if (wrap_ev) begin
            next_wrap_flag = 1'b1;
        end
    end

    // Read data is held only in the cycle after the read strobe.
    always_comb begin
        next_rdata = RESET_WORD;
        if (RD) begin
            unique case (ADDR)
                ADDR_MODE: next_rdata = {12'h000, mode_sel,
                    clear_toggle_sel, wrap_flag};
                ADDR_CAPCMP: next_rdata = {13'h0000, b_capture,
                    reverse_phase_sel, a_capture};
                ADDR_OUTCTL: next_rdata = {14'h0000, output_control};
                ADDR_PRESCALE: next_rdata = {8'h00, edge_b_sel,
                    edge_a_sel, 2'h0, prescale_select};
                ADDR_COUNTER: next_rdata = up_counter;
                ADDR_REG_A: next_rdata = capcmp_reg_a;
                ADDR_REG_B: next_rdata = capcmp_reg_b;
                default: next_rdata = RESET_WORD;
            endcase
        end
    end

    // All state of the block apart from the two edge qualifiers.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            mode_sel <= MODE_STOP;
            clear_toggle_sel <= 1'b0;
            wrap_flag <= 1'b0;
            a_capture <= 1'b0;
            reverse_phase_sel <= 1'b0;
            b_capture <= 1'b0;
            output_control <= TOG_NONE;
            prescale_select <= 2'h0;
            edge_a_sel <= EDGE_FALL;
            edge_b_sel <= EDGE_FALL;
            up_counter <= RESET_WORD;
            capcmp_reg_a <= RESET_WORD;
            capcmp_reg_b <= RESET_WORD;
            div_count <= DIV_LIMIT_0;
            RDATA <= RESET_WORD;
            TOGGLE_OUT <= 1'b0;
            IRQ_A <= 1'b0;
            IRQ_B <= 1'b0;
        end else begin
            mode_sel <= next_mode_sel;
            clear_toggle_sel <= next_clear_toggle_sel;
            wrap_flag <= next_wrap_flag;
            a_capture <= next_a_capture;
            reverse_phase_sel <= next_reverse_phase_sel;
            b_capture <= next_b_capture;
            output_control <= next_output_control;
            prescale_select <= next_prescale_select;
            edge_a_sel <= next_edge_a_sel;
            edge_b_sel <= next_edge_b_sel;
            up_counter <= next_up_counter;
            capcmp_reg_a <= next_capcmp_reg_a;
            capcmp_reg_b <= next_capcmp_reg_b;
            div_count <= next_div_count;
            RDATA <= next_rdata;
            TOGGLE_OUT <= next_toggle_out;
            IRQ_A <= next_irq_a;
            IRQ_B <= next_irq_b;
        end
    end

    // Checks on the behaviour above; a clear zeroes the very next count.
    sequence clear_seq;
        clear_ev ##1 (up_counter == RESET_WORD);
    endsequence

    clear_start_a: assert property (clear_ev |-> clear_seq)
        else $error("Counter not zero after trigger A clear.");
    capture_b_a: assert property (cap_b_ev |=>
        capcmp_reg_b == $past(up_counter) && IRQ_B)
        else $error("Register B did not capture the count.");
    capture_a_a: assert property (cap_a_ev |=>
        capcmp_reg_a == $past(up_counter))
        else $error("Register A did not capture the count.");
    rev_quiet_a: assert property (
        cap_a_ev && reverse_phase_sel && !edge_b_valid |=> !IRQ_A)
        else $error("Reverse-phase capture raised interrupt A.");
    b_edge_irq_a: assert property (
        b_irq_only && !cap_a_ev && !(WR && ADDR == ADDR_REG_A)
        |=> IRQ_A && $stable(capcmp_reg_a))
        else $error("Edge B in reverse phase mishandled.");
    wrap_flag_a: assert property (wrap_ev |=>
        wrap_flag && up_counter == RESET_WORD)
        else $error("Wrap did not set flag and zero counter.");
    match_keep_a: assert property (match_a && !clear_ev |=>
        IRQ_A && up_counter == $past(up_counter) + COUNT_ONE)
        else $error("Match A altered the count or lost its pulse.");
    toggle_out_a: assert property (toggle_ev |=>
        TOGGLE_OUT != $past(TOGGLE_OUT))
        else $error("Output did not invert on a toggle event.");
    match_b_tog_a: assert property (
        match_b && output_control == TOG_B && !clear_toggle_sel
        |=> TOGGLE_OUT != $past(TOGGLE_OUT) && IRQ_B)
        else $error("Match B did not toggle under field 10.");
    count_run_a: assert property (
        running && tick && !clear_ev && !(WR && ADDR == ADDR_MODE)
        |=> up_counter == $past(up_counter) + COUNT_ONE)
        else $error("Counter did not advance on the tick.");

endmodule // ecct_timer

// >>> src/ecct_pkg.sv
package ecct_pkg;

    // Register word indices on the plain register port.
    localparam logic [2:0] ADDR_MODE = 3'h0;
    localparam logic [2:0] ADDR_CAPCMP = 3'h1;
    localparam logic [2:0] ADDR_OUTCTL = 3'h2;
    localparam logic [2:0] ADDR_PRESCALE = 3'h3;
    localparam logic [2:0] ADDR_COUNTER = 3'h4;
    localparam logic [2:0] ADDR_REG_A = 3'h5;
    localparam logic [2:0] ADDR_REG_B = 3'h6;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;

    // Field positions in the mode register.
    localparam int MODE_WRAP_BIT = 0;
    localparam int MODE_CLRTOG_BIT = 1;
    localparam int MODE_LO_BIT = 2;

    // Field positions in the capture/compare control register.
    localparam int CC_A_CAP_BIT = 0;
    localparam int CC_REV_BIT = 1;
    localparam int CC_B_CAP_BIT = 2;

    // Field positions in the prescale register.
    localparam int PS_DIV_LO = 0;
    localparam int PS_EDGE_A_LO = 4;
    localparam int PS_EDGE_B_LO = 6;

    // Operating modes held in the two mode-select bits.
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_CLEAR = 2'h2;

    // Trigger edge selections.
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_NONE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Output toggle field encodings.
    localparam logic [1:0] TOG_NONE = 2'h0;
    localparam logic [1:0] TOG_A = 2'h1;
    localparam logic [1:0] TOG_B = 2'h2;
    localparam logic [1:0] TOG_BOTH = 2'h3;

    // Prescaler terminal counts for divide by 1, 4, 16 and 64.
    localparam logic [5:0] DIV_LIMIT_0 = 6'h00;
    localparam logic [5:0] DIV_LIMIT_1 = 6'h03;
    localparam logic [5:0] DIV_LIMIT_2 = 6'h0F;
    localparam logic [5:0] DIV_LIMIT_3 = 6'h3F;

    // Values after reset and the counter's top value.
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

endpackage : ecct_pkg

// >>> src/ecct_edge_qual.sv
// Synchronises one trigger pin and accepts a level change only after it
// has been seen on two consecutive sample ticks.
module ecct_edge_qual (
    input wire logic clock,
    input wire logic srst,
    input wire logic pin,
    input wire logic sample,
    output logic rise,
    output logic fall
);
    import ecct_pkg::*;

    logic sync_1;
    logic sync_2;
    logic last_sample;
    logic stable;
    logic next_last_sample;
    logic next_stable;
    logic next_rise;
    logic next_fall;

    // The pin is asynchronous, so only the second stage is looked at.
    always_ff @(posedge clock) begin
        sync_1 <= pin;
        sync_2 <= sync_1;
    end

    // A change counts once two samples in a row agree on the new level.
    // two-sample qualification
    always_comb begin
        next_last_sample = last_sample;
        next_stable = stable;
        next_rise = 1'b0;
        next_fall = 1'b0;
        if (sample) begin
            next_last_sample = sync_2;
            if (sync_2 == last_sample && sync_2 != stable) begin
                next_stable = sync_2;
                next_rise = sync_2;
                next_fall = ~sync_2;
            end
        end
    end

    // Registers of the qualifier.
    always_ff @(posedge clock) begin
        if (srst) begin
            last_sample <= 1'b0;
            stable <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            last_sample <= next_last_sample;
            stable <= next_stable;
            rise <= next_rise;
            fall <= next_fall;
        end
    end

    // A rise is registered one cycle after two high samples over a low
    // stable level, so the history is looked at one cycle back.
    sequence two_high_s;
        $past(sync_2) && $past(last_sample) && !$past(stable);
    endsequence

    qual_rise_a: assert property (@(posedge clock) disable iff (srst)
        rise |-> two_high_s)
        else $error("Rise accepted without two high samples.");

endmodule // ecct_edge_qual

// >>> tb/ecct_trig_model.sv
// Stands in for the two external trigger sources. Both pins idle low, as a
// pulled-down source would, and only move when the bench asks.
module ecct_trig_model (
    input wire logic clock,
    output logic trig_a,
    output logic trig_b
);
    timeunit 1ns;
    timeprecision 100ps;

    // Pins start low so the first edge seen by the timer is a rise.
    initial begin
        trig_a = 1'b0;
        trig_b = 1'b0;
    end

    // Each level is held for the given count of cycles; a count of one is
    // a glitch that the timer must reject.
    // level hold
    task automatic set_a(input logic lvl, input int hold);
        @(posedge clock);
        trig_a <= lvl;
        repeat (hold - 1) @(posedge clock);
    endtask

    // Pin B never looks at the timer output, so it cannot depend on it.
    // output unused
    task automatic set_b(input logic lvl, input int hold);
        @(posedge clock);
        trig_b <= lvl;
        repeat (hold - 1) @(posedge clock);
    endtask
endmodule // ecct_trig_model

// >>> tb/ecct_timer_tb.sv
module ecct_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ecct_pkg::*;

    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic toggle_out, irq_a, irq_b, pin_a, pin_b, tog_q;
    int err_count = 0;
    int cmp_count = 0;
    int n_irq_a, n_irq_b, n_tog, ea, eb, et;
    logic [15:0] v, w, x;

    ecct_timer u_dut (.CLOCK(clock), .SRST(srst), .ADDR(addr),
        .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
        .TRIGGER_IN_A(pin_a), .TRIGGER_IN_B(pin_b),
        .TOGGLE_OUT(toggle_out), .IRQ_A(irq_a), .IRQ_B(irq_b));

    ecct_trig_model u_trig (.clock(clock), .trig_a(pin_a), .trig_b(pin_b));

    // 50 MHz clock.
    always #10 clock = ~clock;

    // Counts interrupt cycles and output flips; a pulse wider than one
    // cycle shows up as an extra count.
    always @(posedge clock) begin
        if (srst) begin
            n_irq_a <= 0;
            n_irq_b <= 0;
            n_tog <= 0;
            tog_q <= 1'b0;
        end else begin
            if (irq_a === 1'b1) n_irq_a <= n_irq_a + 1;
            if (irq_b === 1'b1) n_irq_b <= n_irq_b + 1;
            if (toggle_out !== tog_q) n_tog <= n_tog + 1;
            tog_q <= toggle_out;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock);
        wr_s <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clock);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock);
        rd_s <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_in(input string nm, input logic [15:0] lo,
                          input logic [15:0] hi, input logic [15:0] g);
        cmp_count++;
        if ((^g) === 1'bx || g < lo || g > hi) begin
            err_count++;
            $display("FAIL %s expected %h..%h seen %h", nm, lo, hi, g);
        end
    endtask

    task automatic wrap_up;
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cuts a hang short well past the longest planned sequence.
    initial begin
        repeat (90000) @(posedge clock);
        err_count++;
        wrap_up();
    end

    // Main sequence; every wait below is a fixed count of clock cycles.
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), v);
            chk("reset word", RESET_WORD, v);
        end
        // Free-run rate at divide by 1 and by 4; a counter write is lost.
        wr(ADDR_MODE, 16'h0004);
        wr(ADDR_COUNTER, 16'h1234);
        rd(ADDR_COUNTER, v);
        chk_in("counter read only", 16'h0000, 16'h0010, v);
        rd(ADDR_COUNTER, v);
        rd(ADDR_COUNTER, w);
        chk("count step", 16'h0002, w - v);
        wr(ADDR_PRESCALE, 16'h0001);
        rd(ADDR_COUNTER, v);
        cyc(6);
        rd(ADDR_COUNTER, w);
        chk("count step div4", 16'h0002, w - v);
        // Clear-and-start, both capturing, edge A both, clear-toggle on.
        wr(ADDR_PRESCALE, 16'h00B0);
        wr(ADDR_CAPCMP, 16'h0005);
        wr(ADDR_MODE, 16'h000A);
        // Zero-valued compare registers matched at the free-run start.
        ea = n_irq_a;
        eb = n_irq_b;
        et = n_tog;
        cyc(30);
        u_trig.set_a(1'b1, 1);
        u_trig.set_a(1'b0, 10);
        chk("glitch irq_b", 16'(eb), 16'(n_irq_b));
        rd(ADDR_COUNTER, v);
        u_trig.set_a(1'b1, 12);
        rd(ADDR_REG_B, w);
        chk_in("capture before clear", v + 2, v + 10, w);
        rd(ADDR_COUNTER, x);
        chk_in("counter cleared", 16'h0000, 16'h0010, x);
        chk("capture irq_b", 16'(eb + 1), 16'(n_irq_b));
        chk("clear toggles", 16'(et + 1), 16'(n_tog));
        u_trig.set_a(1'b0, 12);
        chk("fall irq_b", 16'(eb + 2), 16'(n_irq_b));
        chk("fall toggles", 16'(et + 2), 16'(n_tog));
        chk("no irq_a", 16'(ea), 16'(n_irq_a));
        // Pulse width with reverse phase; edge A and edge B falling.
        wr(ADDR_PRESCALE, 16'h0000);
        wr(ADDR_CAPCMP, 16'h0007);
        wr(ADDR_MODE, 16'h0008);
        ea = n_irq_a;
        eb = n_irq_b;
        u_trig.set_a(1'b1, 40);
        u_trig.set_a(1'b0, 12);
        rd(ADDR_REG_A, v);
        rd(ADDR_REG_B, w);
        chk("high width", 16'd40, w - v);
        chk("reverse no irq_a", 16'(ea), 16'(n_irq_a));
        chk("width irq_b", 16'(eb + 1), 16'(n_irq_b));
        u_trig.set_b(1'b1, 12);
        u_trig.set_b(1'b0, 12);
        rd(ADDR_REG_A, x);
        chk("pin b no capture", v, x);
        chk("pin b irq_a", 16'(ea + 1), 16'(n_irq_a));
        // Free-run, A captures from B both edges, B from A rising.
        wr(ADDR_PRESCALE, 16'h00D0);
        wr(ADDR_CAPCMP, 16'h0005);
        wr(ADDR_MODE, 16'h0004);
        ea = n_irq_a;
        eb = n_irq_b;
        et = n_tog;
        u_trig.set_b(1'b1, 10);
        rd(ADDR_REG_A, v);
        cyc(18);
        u_trig.set_b(1'b0, 12);
        rd(ADDR_REG_A, w);
        chk("b edge width", 16'd30, w - v);
        u_trig.set_a(1'b1, 12);
        rd(ADDR_REG_B, w);
        rd(ADDR_COUNTER, x);
        chk_in("free no clear", 16'h0001, 16'h0014, x - w);
        chk("b edges irq_a", 16'(ea + 2), 16'(n_irq_a));
        chk("a edge irq_b", 16'(eb + 1), 16'(n_irq_b));
        chk("no toggle", 16'(et), 16'(n_tog));
        // Both comparing, every toggle code.
        wr(ADDR_CAPCMP, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_OUTCTL, 16'(c));
            ea = n_irq_a;
            eb = n_irq_b;
            et = n_tog;
            rd(ADDR_COUNTER, v);
            wr(ADDR_REG_A, v + 16'd20);
            wr(ADDR_REG_B, v + 16'd40);
            cyc(50);
            chk("match irq_a", 16'(ea + 1), 16'(n_irq_a));
            chk("match irq_b", 16'(eb + 1), 16'(n_irq_b));
            chk("match toggles", 16'(et + (c & 1) + (c >> 1)),
                16'(n_tog));
            rd(ADDR_COUNTER, x);
            chk_in("match no clear", v + 16'd50, v + 16'd70, x);
        end
        // Wrap flag sets past the top count and stays until cleared.
        cyc(65600);
        rd(ADDR_MODE, v);
        chk("wrap flag set", 16'h0001, {15'h0000, v[MODE_WRAP_BIT]});
        wr(ADDR_MODE, 16'h0004);
        rd(ADDR_MODE, v);
        chk("wrap flag clear", 16'h0000, {15'h0000, v[MODE_WRAP_BIT]});
        // Slower count rates, then the stopped mode code 11.
        wr(ADDR_PRESCALE, 16'h0002);
        rd(ADDR_COUNTER, v);
        cyc(30);
        rd(ADDR_COUNTER, w);
        chk("count step div16", 16'h0002, w - v);
        wr(ADDR_PRESCALE, 16'h0003);
        rd(ADDR_COUNTER, v);
        cyc(126);
        rd(ADDR_COUNTER, w);
        chk("count step div64", 16'h0002, w - v);
        wr(ADDR_MODE, 16'h000C);
        rd(ADDR_COUNTER, v);
        chk("mode 11 stopped", RESET_WORD, v);
        wrap_up();
    end
endmodule // ecct_timer_tb
